/* File: core/edge_timing_regs.svh */
// register offsets, field positions and timing constants of the edge timing block
`ifndef EDGE_TIMING_REGS_SVH
`define EDGE_TIMING_REGS_SVH
`define OFS_OUT_C_RISE_TIME_HIGH 8'h49
`define OFS_OUT_C_RISE_SETTING 8'h4A
`define OFS_OUT_C_FALL_TIME_HIGH 8'h4B
`define OFS_OUT_C_FALL_SETTING 8'h4C
`define OFS_OUT_D_RISE_TIME_HIGH 8'h4D
`define OFS_OUT_D_RISE_SETTING 8'h4E
`define OFS_OUT_D_FALL_TIME_HIGH 8'h4F
`define OFS_OUT_D_FALL_SETTING 8'h50
`define OFS_RECT1_RISE_TIME_HIGH 8'h51
`define OFS_RECT1_RISE_SETTING 8'h52
`define OFS_EDGE_STATUS 8'h60
`define OFS_EDGE_CONTROL 8'h61
`define EDGE_REG_COUNT 10
`define EDGE_COUNT 5
`define REG_RESET 8'h00
`define FLD_LSB_HI 7
`define FLD_LSB_LO 4
`define FLD_MOD_EN 3
`define FLD_SIGN 2
`define FLD_RUN 0
`define EDGE_TIME_MAX 12'hFFF
`define EDGE_STEP_NS 5
`define CLK_PERIOD_NS 5
`define STEP_CYCLES ((`EDGE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_STEPS_DEFAULT 4096
`endif

/* File: core/edge_timing_pkg.sv */
// types and helpers shared by the edge timing modules
`default_nettype none
package edge_timing_pkg;
	typedef logic [11:0] edge_time_t;
	typedef logic [7:0] reg_byte_t;
	typedef enum logic [2:0] {
		EDGE_THIRD_RISE = 3'h0,
		EDGE_THIRD_FALL = 3'h1,
		EDGE_FOURTH_RISE = 3'h2,
		EDGE_FOURTH_FALL = 3'h3,
		EDGE_RECT_RISE = 3'h4
	} edge_id_t;

	// eight msbs from the timing byte, four lsbs from the setting upper nibble
	function automatic edge_time_t compose_time(input reg_byte_t high_b, input reg_byte_t set_b);
		return {high_b, set_b[7:4]};
	endfunction : compose_time
endpackage : edge_timing_pkg
`default_nettype wire

/* File: core/edge_cfg_if.sv */
// per-edge setting and applied timing between the register file and an edge unit
`timescale 1ns/1ps
`default_nettype none
interface edge_cfg_if;
	edge_timing_pkg::edge_time_t time_w;
	logic mod_en;
	logic sign;
	logic load;
	edge_timing_pkg::edge_time_t held;
	logic en_held;
	logic sign_held;
	edge_timing_pkg::edge_time_t amt_held;
	edge_timing_pkg::edge_time_t eff;
	modport ctl(output time_w, mod_en, sign, load, input held, en_held, sign_held, amt_held, eff);
	modport unit(input time_w, mod_en, sign, load, output held, en_held, sign_held, amt_held, eff);
endinterface : edge_cfg_if
`default_nettype wire

/* File: core/period_timer.sv */
// switching period counter in edge steps, with a period boundary pulse
`timescale 1ns/1ps
`default_nettype none
`include "edge_timing_regs.svh"
module period_timer #(
	parameter int PERIOD_STEPS = `PERIOD_STEPS_DEFAULT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic run,
	output logic [11:0] cnt_q,
	output logic boundary
);
	localparam logic [11:0] LAST = 12'(PERIOD_STEPS - 1);
	localparam logic [7:0] STEP_LAST = 8'(`STEP_CYCLES - 1);
	logic [7:0] presc_q;
	logic tick;

	if (PERIOD_STEPS < 2 || PERIOD_STEPS > 4096 || `STEP_CYCLES > 256) begin : g_bad
		$error("period_timer: unsupported period or step");
	end

	assign tick = (presc_q == STEP_LAST);
	// a stopped timer parks on the last step so that start is a boundary
	assign boundary = run && tick && (cnt_q == LAST);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_q <= 8'h00;
		end else if (!run || tick) begin
			presc_q <= 8'h00;
		end else begin
			presc_q <= presc_q + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 12'h000;
		end else if (!run || boundary) begin
			cnt_q <= run ? 12'h000 : LAST;
		end else if (tick) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end
endmodule : period_timer
`default_nettype wire

/* File: core/edge_unit.sv */
// one edge: setting shadow taken at the boundary and the modulated edge time
`timescale 1ns/1ps
`default_nettype none
`include "edge_timing_regs.svh"
module edge_unit #(
	parameter int MOD_W = 12
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [MOD_W-1:0] mod_amount,
	edge_cfg_if.unit cfg
);
	if (MOD_W < 1 || MOD_W > 12) begin : g_bad_mod
		$error("edge_unit: modulation width must be 1 to 12");
	end

	// saturate instead of wrapping so a large correction never folds an edge into the next period
	function automatic edge_timing_pkg::edge_time_t apply_mod(input edge_timing_pkg::edge_time_t t,
			input logic en, input logic sign, input edge_timing_pkg::edge_time_t m);
		logic [12:0] sum;
		sum = {1'b0, t} + {1'b0, m};
		if (!en) begin
			return t;
		end else if (sign) begin
			return sum[12] ? `EDGE_TIME_MAX : sum[11:0];
		end else begin
			return (m > t) ? 12'h000 : 12'(t - m);
		end
	endfunction : apply_mod

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg.held <= 12'h000;
			cfg.en_held <= 1'b0;
			cfg.sign_held <= 1'b0;
			cfg.amt_held <= 12'h000;
		end else if (cfg.load) begin
			cfg.held <= cfg.time_w;
			cfg.en_held <= cfg.mod_en;
			cfg.sign_held <= cfg.sign;
			cfg.amt_held <= 12'(mod_amount);
		end
	end

	assign cfg.eff = apply_mod(cfg.held, cfg.en_held, cfg.sign_held, cfg.amt_held);
endmodule : edge_unit
`default_nettype wire

/* File: core/pwm_edge_timing.sv */
// edge timing registers and pulse generation for the third, fourth and rectifier drives
// Notes on behaviour
// - third drive rise time is timing byte msbs plus setting bits 7:4 lsbs.
// - third drive fall time is formed the same way from its two registers.
// - fourth drive rise time always uses both its msb and lsb registers.
// - fourth drive fall time: msbs byte, lsbs in bits 7:4 of next register.
// - rectifier first rise time: msbs byte joined with next register upper nibble.
// - each edge time lsb equals 5 ns, one step of the period counter.
// - setting bit 3 lets loop modulation shift the edge; else edge stays fixed.
// - sign bit 2 set: more modulation moves the edge later.
// - sign bit 2 clear: more modulation moves the edge earlier.
`timescale 1ns/1ps
`default_nettype none
`include "edge_timing_regs.svh"
module pwm_edge_timing #(
	parameter int MOD_W = 12,
	parameter int PERIOD_STEPS = `PERIOD_STEPS_DEFAULT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [MOD_W-1:0] mod_amount,
	output logic primary_drive_third,
	output logic primary_drive_fourth,
	output logic rectifier_drive_first
);
	edge_timing_pkg::reg_byte_t regs_q [`EDGE_REG_COUNT];
	logic run_q;
	logic [11:0] cnt;
	logic boundary;
	logic in_edge_range;
	logic [3:0] reg_idx;
	logic third_q;
	logic fourth_q;
	logic rect_q;
	edge_timing_pkg::edge_time_t eff [`EDGE_COUNT];
	localparam logic [11:0] PERIOD_LAST = 12'(PERIOD_STEPS - 1);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// half-open window: a rise at or after the fall gives no pulse at all
	function automatic logic in_window(input logic [11:0] c, input edge_timing_pkg::edge_time_t rise_t,
			input edge_timing_pkg::edge_time_t fall_t);
		return (c >= rise_t) && (c < fall_t);
	endfunction : in_window

	if (MOD_W < 1 || MOD_W > 12) begin : g_bad_mod
		$error("pwm_edge_timing: modulation width must be 1 to 12");
	end

	assign in_edge_range = (reg_addr >= `OFS_OUT_C_RISE_TIME_HIGH) && (reg_addr <= `OFS_RECT1_RISE_SETTING);
	assign reg_idx = 4'(reg_addr - `OFS_OUT_C_RISE_TIME_HIGH);

	// reserved bits are stored as written; they have no effect here
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < `EDGE_REG_COUNT; i++) begin
				regs_q[i] <= `REG_RESET;
			end
		end else if (reg_wr && in_edge_range) begin
			regs_q[reg_idx] <= reg_wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_q <= 1'b0;
		end else if (reg_wr && reg_addr == `OFS_EDGE_CONTROL) begin
			run_q <= reg_wdata[`FLD_RUN];
		end
	end

	// read data stand in the cycle after each cycle with reg_rd high, zero otherwise
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (in_edge_range) begin
			reg_rdata <= regs_q[reg_idx];
		end else if (reg_addr == `OFS_EDGE_STATUS) begin
			reg_rdata <= {4'h0, run_q, rect_q, fourth_q, third_q};
		end else if (reg_addr == `OFS_EDGE_CONTROL) begin
			reg_rdata <= {7'h00, run_q};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// one counter step per edge lsb
	period_timer #(
		.PERIOD_STEPS(PERIOD_STEPS)
	) u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(run_q),
		.cnt_q(cnt),
		.boundary(boundary)
	);

	edge_cfg_if cfg [`EDGE_COUNT] ();

	for (genvar e = 0; e < `EDGE_COUNT; e++) begin : g_edge
		// both halves go together; the unit takes them only at the boundary
		assign cfg[e].time_w = edge_timing_pkg::compose_time(regs_q[2*e], regs_q[2*e+1]);
		assign cfg[e].mod_en = regs_q[2*e+1][`FLD_MOD_EN];
		assign cfg[e].sign = regs_q[2*e+1][`FLD_SIGN];
		assign cfg[e].load = boundary;
		assign eff[e] = cfg[e].eff;

		edge_unit #(
			.MOD_W(MOD_W)
		) u_edge (
			.clk(clk),
			.sys_rst(sys_rst),
			.mod_amount(mod_amount),
			.cfg(cfg[e])
		);

		edge_compose_a: assert property (
			boundary |=> cfg[e].held ==
				edge_timing_pkg::compose_time($past(regs_q[2*e]), $past(regs_q[2*e+1])))
			else $error("applied edge time does not match its register pair");
		edge_hold_a: assert property (
			!boundary |=> $stable(cfg[e].held) && $stable(cfg[e].en_held)
				&& $stable(cfg[e].sign_held) && $stable(cfg[e].amt_held))
			else $error("applied edge changed inside a period");
		edge_fixed_a: assert property (
			!cfg[e].en_held |-> cfg[e].eff == cfg[e].held)
			else $error("unmodulated edge moved");
		edge_later_a: assert property (
			cfg[e].en_held && cfg[e].sign_held |->
				cfg[e].eff == ((13'(cfg[e].held) + 13'(cfg[e].amt_held) > 13'h0FFF) ?
					`EDGE_TIME_MAX : 12'(cfg[e].held + cfg[e].amt_held)))
			else $error("positive sign edge not moved later by the modulation");
		edge_earlier_a: assert property (
			cfg[e].en_held && !cfg[e].sign_held |->
				cfg[e].eff == ((cfg[e].amt_held > cfg[e].held) ? 12'h000 : 12'(cfg[e].held - cfg[e].amt_held)))
			else $error("negative sign edge not moved earlier by the modulation");
		edge_latch_a: assert property (
			boundary |=> cfg[e].en_held == $past(regs_q[2*e+1][`FLD_MOD_EN])
				&& cfg[e].sign_held == $past(regs_q[2*e+1][`FLD_SIGN]))
			else $error("edge enable or sign not taken at the boundary");
		mod_latch_a: assert property (
			boundary |=> cfg[e].amt_held == 12'($past(mod_amount)))
			else $error("modulation amount not taken at the boundary");
	end

	// drives are flops: each follows the counter one clock later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			third_q <= 1'b0;
		end else begin
			third_q <= run_q && in_window(cnt, eff[edge_timing_pkg::EDGE_THIRD_RISE],
				eff[edge_timing_pkg::EDGE_THIRD_FALL]);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fourth_q <= 1'b0;
		end else begin
			fourth_q <= run_q && in_window(cnt, eff[edge_timing_pkg::EDGE_FOURTH_RISE],
				eff[edge_timing_pkg::EDGE_FOURTH_FALL]);
		end
	end

	// the rectifier falling edge is handled elsewhere; here it ends with the period
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rect_q <= 1'b0;
		end else begin
			rect_q <= run_q && cnt >= eff[edge_timing_pkg::EDGE_RECT_RISE];
		end
	end

	assign primary_drive_third = third_q;
	assign primary_drive_fourth = fourth_q;
	assign rectifier_drive_first = rect_q;

	read_edge_reg_a: assert property (
		reg_rd && in_edge_range |=> reg_rdata == $past(regs_q[reg_idx]))
		else $error("edge register read back wrong");
	read_unmapped_a: assert property (
		reg_rd && !in_edge_range && reg_addr != `OFS_EDGE_STATUS && reg_addr != `OFS_EDGE_CONTROL
			|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	third_level_a: assert property (
		run_q && cnt == eff[edge_timing_pkg::EDGE_THIRD_RISE]
			&& cnt < eff[edge_timing_pkg::EDGE_THIRD_FALL] |=> primary_drive_third)
		else $error("third drive not high one clock after its rise step");
	third_fall_a: assert property (
		run_q && cnt == eff[edge_timing_pkg::EDGE_THIRD_FALL] |=> !primary_drive_third)
		else $error("third drive not low one clock after its fall step");
	rect_stop_a: assert property (
		!run_q |=> !rectifier_drive_first && !primary_drive_fourth)
		else $error("drive active while stopped");
	third_stop_a: assert property (
		!run_q |=> !primary_drive_third)
		else $error("third drive active while stopped");

	third_before_a: assert property (
		run_q && cnt < eff[edge_timing_pkg::EDGE_THIRD_RISE] |=> !primary_drive_third)
		else $error("third drive high before its rise step");
	fourth_rise_a: assert property (
		run_q && cnt == eff[edge_timing_pkg::EDGE_FOURTH_RISE]
			&& cnt < eff[edge_timing_pkg::EDGE_FOURTH_FALL] |=> primary_drive_fourth)
		else $error("fourth drive not high one clock after its rise step");
	fourth_before_a: assert property (
		run_q && cnt < eff[edge_timing_pkg::EDGE_FOURTH_RISE] |=> !primary_drive_fourth)
		else $error("fourth drive high before its rise step");
	fourth_fall_a: assert property (
		run_q && cnt >= eff[edge_timing_pkg::EDGE_FOURTH_FALL] |=> !primary_drive_fourth)
		else $error("fourth drive not low after its fall step");
	rect_rise_a: assert property (
		run_q && cnt >= eff[edge_timing_pkg::EDGE_RECT_RISE] |=> rectifier_drive_first)
		else $error("rectifier drive not high after its rise step");
	rect_before_a: assert property (
		run_q && cnt < eff[edge_timing_pkg::EDGE_RECT_RISE] |=> !rectifier_drive_first)
		else $error("rectifier drive high before its rise step");

	// the counter is the time base of every edge, so its ends are pinned down too
	parked_a: assert property (
		!run_q |=> cnt == PERIOD_LAST)
		else $error("stopped counter not parked on the last step");
	period_wrap_a: assert property (
		boundary |=> cnt == 12'h000)
		else $error("counter did not wrap at the boundary");
	start_boundary_a: assert property (
		$rose(run_q) |-> boundary)
		else $error("start did not begin with a boundary");

	write_lands_a: assert property (
		reg_wr && in_edge_range |=> regs_q[$past(reg_idx)] == $past(reg_wdata))
		else $error("edge register write did not land");
	run_write_a: assert property (
		reg_wr && reg_addr == `OFS_EDGE_CONTROL |=> run_q == $past(reg_wdata[`FLD_RUN]))
		else $error("control write did not set run");
	status_write_a: assert property (
		reg_wr && reg_addr == `OFS_EDGE_STATUS |=> $stable(run_q))
		else $error("status write changed run");
	read_status_a: assert property (
		reg_rd && reg_addr == `OFS_EDGE_STATUS |=> reg_rdata == {4'h0, $past(run_q), $past(rect_q),
			$past(fourth_q), $past(third_q)})
		else $error("status read back wrong");
	read_control_a: assert property (
		reg_rd && reg_addr == `OFS_EDGE_CONTROL |=> reg_rdata == {7'h00, $past(run_q)})
		else $error("control read back wrong");
	read_idle_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");

	start_c: cover property (!run_q ##1 (run_q && boundary));
	third_pulse_c: cover property (!primary_drive_third ##1 primary_drive_third ##[1:64] !primary_drive_third);
	modulated_c: cover property (
		cfg[0].en_held && cfg[0].sign_held && cfg[0].amt_held != 12'h000 && run_q);
	earlier_c: cover property (
		cfg[0].en_held && !cfg[0].sign_held && cfg[0].amt_held != 12'h000 && run_q);
	fourth_pulse_c: cover property (!primary_drive_fourth ##1 primary_drive_fourth ##[1:64] !primary_drive_fourth);
endmodule : pwm_edge_timing
`default_nettype wire

/* File: tb/gate_stage_model.sv */
// gate driver stage model: counts the on-steps of each drive over a window
`timescale 1ns/1ps
`default_nettype none
module gate_stage_model (
	input wire logic clk,
	input wire logic clr,
	input wire logic gate_third,
	input wire logic gate_fourth,
	input wire logic gate_rect,
	output logic [7:0] on_third,
	output logic [7:0] on_fourth,
	output logic [7:0] on_rect
);
	// whole-step on-time only: the stage cannot see sub-step slivers anyway
	always @(posedge clk) begin
		if (clr) begin
			on_third <= 8'h00;
			on_fourth <= 8'h00;
			on_rect <= 8'h00;
		end else begin
			on_third <= on_third + 8'(gate_third);
			on_fourth <= on_fourth + 8'(gate_fourth);
			on_rect <= on_rect + 8'(gate_rect);
		end
	end
endmodule : gate_stage_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the edge timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {logic [7:0] ah; logic [7:0] al; logic [7:0] bh; logic [7:0] bl; logic [11:0] m;
		logic [7:0] w3; logic [7:0] wr;} row_t;
	// short period keeps runs small while still reaching the msb byte
	localparam int PER = 64;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [11:0] mod_amount = 12'h000;
	logic d3, d4, dr;
	logic clr = 1'b0;
	logic [7:0] c3, c4, cr;
	int mismatches = 0;
	int n_compared = 0;
	row_t rows [6];
	always #2.5 clk = ~clk;
	pwm_edge_timing #(.MOD_W(12), .PERIOD_STEPS(PER)) pwm_edge_timing_inst (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mod_amount(mod_amount), .primary_drive_third(d3), .primary_drive_fourth(d4), .rectifier_drive_first(dr));
	gate_stage_model gate_stage_model_inst (.clk(clk), .clr(clr), .gate_third(d3), .gate_fourth(d4),
		.gate_rect(dr), .on_third(c3), .on_fourth(c4), .on_rect(cr));
	task automatic final_report;
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask : rd
	// same pair goes to third rise, fourth rise and rectifier rise; the other to both falls
	task automatic cfg(input row_t r);
		for (int i = 0; i < 5; i++) begin
			wr(8'(8'h49 + 2 * i), (i == 1 || i == 3) ? r.bh : r.ah);
			wr(8'(8'h4A + 2 * i), (i == 1 || i == 3) ? r.bl : r.al);
		end
		mod_amount <= r.m;
		// new values only land at a boundary, so let one pass before measuring
		repeat (PER + 16) @(posedge clk);
	endtask : cfg
	task automatic measure(input logic [7:0] w3, input logic [7:0] wr_exp);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (PER) @(posedge clk);
		#1;
		chk("third on-steps", w3, c3);
		chk("fourth on-steps", w3, c4);
		chk("rect on-steps", wr_exp, cr);
	endtask : measure
	initial begin
		// run is about 1260 cycles; the limit leaves ample margin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report;
	end
	initial begin
		rows = '{'{8'h00, 8'h50, 8'h01, 8'h40, 12'h007, 8'h0F, 8'h3B},
			'{8'h00, 8'h5C, 8'h01, 8'h40, 12'h004, 8'h0B, 8'h37},
			'{8'h00, 8'h58, 8'h01, 8'h40, 12'h004, 8'h13, 8'h3F},
			'{8'h00, 8'h50, 8'h01, 8'h48, 12'h004, 8'h0B, 8'h3B},
			'{8'h00, 8'h28, 8'h01, 8'h40, 12'h00A, 8'h14, 8'h40},
			'{8'h01, 8'h40, 8'h00, 8'h50, 12'h000, 8'h00, 8'h2C}};
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 8'h49; a <= 8'h52; a++) begin
			rd(8'(a), 8'h00, "reset value");
			wr(8'(a), 8'(a + 8'h11));
			rd(8'(a), 8'(a + 8'h11), "readback");
		end
		wr(8'h70, 8'hFF);
		rd(8'h70, 8'h00, "unmapped read");
		wr(8'h61, 8'h01);
		rd(8'h61, 8'h01, "control readback");
		foreach (rows[i]) begin
			cfg(rows[i]);
			measure(rows[i].w3, rows[i].wr);
		end
		wr(8'h61, 8'h00);
		repeat (4) @(posedge clk);
		measure(8'h00, 8'h00);
		wr(8'h60, 8'hFF);
		rd(8'h60, 8'h00, "status while stopped");
		rd(8'h61, 8'h00, "control after stop");
		wr(8'h61, 8'h01);
		repeat (100) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk("drives in reset", 8'h00, {5'h00, d3, d4, dr});
		@(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h49, 8'h00, "value after reset");
		final_report;
	end
endmodule : tb_top
`default_nettype wire
